// [hw/pcsst_lane_status.sv]
// Receive status, statistics increments and test-pattern control of a four-lane PCS.
`timescale 1ns/1ps

// Function
// - Receive test-pattern bit set checks scrambled idle, unless a higher mode wins.
// - Transmit test-pattern bit one generates scrambled idle, unless a higher mode wins.
// - Clock-compensation FIFO underflow or overflow drives the receive FIFO error high.
// - Local fault follows the decoder initial-state flag, one register stage later.
// - Excess error rate is a level, high while the error rate is over limit.
// - Four-bit block-lock level vector, one bit per lane.
// - Eight-bit test-error count per cycle, active only in receive test mode.
// - Test-error count is a one-cycle pulse with an exact valid indicator.
// - Two-bit code-violation increment, passed through every cycle and meaningful only with its valid.
// - Each lane gives a four-bit sync-header error increment, meaningful with its valid.
// - Each lane has its own increment valid, high when its increment is valid.
// - Aligned is a level, high only while all lanes are aligned and deskewed.
// - While aligned is low the receive path reports a path fault.
module pcsst_lane_status (
  // Clock, reset and enable.
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // AXI4-Lite register port.
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output      logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output      logic                 s_axi_wready,
  output      logic [1:0]           s_axi_bresp,
  output      logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output      logic                 s_axi_arready,
  output      logic [31:0]          s_axi_rdata,
  output      logic [1:0]           s_axi_rresp,
  output      logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output      logic                 irq,
  // Raw receive datapath indications.
  input  wire pcsst_pkg::pcsst_lane_t lane_lock_in,
  input  wire pcsst_pkg::pcsst_nibs_t lane_sh_err_in,
  input  wire pcsst_pkg::pcsst_lane_t lane_word_strobe,
  input  wire logic [1:0]           bad_code_in,
  input  wire logic                 bad_code_strobe,
  input  wire logic                 decoder_in_init,
  input  wire logic                 lanes_deskewed,
  input  wire logic                 ber_over_limit,
  input  wire logic                 cc_fifo_underflow,
  input  wire logic                 cc_fifo_overflow,
  input  wire logic                 rx_higher_mode,
  input  wire pcsst_pkg::pcsst_word_t rx_tp_word,
  input  wire logic [1:0]           rx_tp_header,
  input  wire logic                 rx_tp_strobe,
  // Receive status and increments.
  output      pcsst_pkg::pcsst_lane_t rx_block_lock,
  output      logic                 rx_aligned,
  output      logic                 rx_excess_error_rate,
  output      logic                 rx_local_fault,
  output      logic                 rx_path_fault,
  output      logic                 rx_fifo_error,
  output      pcsst_pkg::pcsst_nibs_t rx_sh_err_inc,
  output      pcsst_pkg::pcsst_lane_t rx_sh_err_valid,
  output      logic [1:0]           rx_bad_code_inc,
  output      logic                 rx_bad_code_valid,
  output      logic [7:0]           rx_test_err_inc,
  output      logic                 rx_test_err_valid,
  output      logic                 rx_port_reset,
  // Transmit stream and static controls.
  input  wire logic                 tx_higher_mode,
  input  wire pcsst_pkg::pcsst_word_t tx_word_in,
  input  wire logic [1:0]           tx_header_in,
  input  wire logic                 tx_strobe_in,
  output      pcsst_pkg::pcsst_word_t tx_word_out,
  output      logic [1:0]           tx_header_out,
  output      logic                 tx_strobe_out,
  output      logic                 tx_port_reset,
  output      logic [15:0]          rx_marker_spacing,
  output      logic [15:0]          tx_marker_spacing,
  output      pcsst_pkg::pcsst_word_t tx_lane2_marker_value,
  output      pcsst_pkg::pcsst_word_t tx_lane3_marker_value
);
  import pcsst_pkg::*;
  `include "pcsst_params.svh"

  pcsst_state_t q;
  pcsst_state_t d;
  pcsst_scr_if  tx_scr ();
  pcsst_scr_if  rx_scr ();
  logic         rx_tp_on;
  logic         tx_tp_on;
  logic         rx_rst;
  logic         tx_rst;
  logic [3:0]   irq_ev;
  logic         wr_ok;
  logic [31:0]  rd_val;
  logic [1:0]   rd_resp;
  logic [15:0]  sh_next;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [7:0] popcount(input logic [65:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 66; i++) begin
      c = c + {7'h00, v[i]};
    end
    return c;
  endfunction : popcount

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode. Higher-precedence modes live outside and simply veto test mode.
  assign rx_rst   = q.ctrl[`PCSST_CTRL_RX_RST];
  assign tx_rst   = q.ctrl[`PCSST_CTRL_TX_RST];
  assign rx_tp_on = q.ctrl[`PCSST_CTRL_RX_TP] & ~rx_higher_mode & ~rx_rst;
  assign tx_tp_on = q.ctrl[`PCSST_CTRL_TX_TP] & ~tx_higher_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit scrambler: test mode feeds idle payload so traffic is replaced.
  assign tx_scr.din       = tx_tp_on ? `PCSST_IDLE_PAYLOAD : tx_word_in;
  assign tx_scr.din_valid = tx_strobe_in & ~tx_rst;
  assign tx_scr.clear     = tx_rst;

  pcsst_scrambler #(.DESCRAMBLE(1'b0)) u_tx_scr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .scr     (tx_scr.core)
  );

  // Receive checker descrambles the test stream and compares it against idle.
  assign rx_scr.din       = rx_tp_word;
  assign rx_scr.din_valid = rx_tp_strobe & rx_tp_on;
  assign rx_scr.clear     = ~rx_tp_on;

  pcsst_scrambler #(.DESCRAMBLE(1'b1)) u_rx_scr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .scr     (rx_scr.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux.
  always_comb begin
    rd_val  = 32'h00000000;
    rd_resp = `PCSST_RESP_OKAY;
    case (s_axi_araddr)
      `PCSST_OFS_CTRL:     rd_val = 32'(q.ctrl);
      `PCSST_OFS_STATUS:   rd_val = {23'h000000, q.pfault, q.fifo_err, q.lfault, q.hi_ber,
                                     q.aligned, q.lock};
      `PCSST_OFS_IRQ_STAT: rd_val = 32'(q.irq_st);
      `PCSST_OFS_IRQ_CLR:  rd_val = 32'h00000000;
      `PCSST_OFS_IRQ_EN:   rd_val = 32'(q.irq_en);
      `PCSST_OFS_SPACING:  rd_val = {q.tx_sp, q.rx_sp};
      `PCSST_OFS_MK2_LO:   rd_val = q.mk2[31:0];
      `PCSST_OFS_MK2_HI:   rd_val = q.mk2[63:32];
      `PCSST_OFS_MK3_LO:   rd_val = q.mk3[31:0];
      `PCSST_OFS_MK3_HI:   rd_val = q.mk3[63:32];
      default:             rd_resp = `PCSST_RESP_SLVERR;
    endcase
  end

  // Markers are refused unless the transmit port reset is held, spacings unless both port resets are held.
  always_comb begin
    case (q.aw_addr)
      `PCSST_OFS_CTRL, `PCSST_OFS_IRQ_CLR, `PCSST_OFS_IRQ_EN: wr_ok = 1'b1;
      `PCSST_OFS_SPACING: wr_ok = rx_rst & tx_rst;
      `PCSST_OFS_MK2_LO, `PCSST_OFS_MK2_HI,
      `PCSST_OFS_MK3_LO, `PCSST_OFS_MK3_HI: wr_ok = tx_rst;
      default: wr_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    d = q;
    irq_ev = 4'h0;
    // Write channel capture, either order.
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = wr_ok ? `PCSST_RESP_OKAY : `PCSST_RESP_SLVERR;
      if (wr_ok) begin
        case (q.aw_addr)
          `PCSST_OFS_CTRL:    d.ctrl = 4'(merge(32'(q.ctrl), q.w_data, q.w_strb));
          `PCSST_OFS_IRQ_EN:  d.irq_en = 4'(merge(32'(q.irq_en), q.w_data, q.w_strb));
          `PCSST_OFS_SPACING: {d.tx_sp, d.rx_sp} = merge({q.tx_sp, q.rx_sp}, q.w_data, q.w_strb);
          `PCSST_OFS_MK2_LO:  d.mk2[31:0]  = merge(q.mk2[31:0], q.w_data, q.w_strb);
          `PCSST_OFS_MK2_HI:  d.mk2[63:32] = merge(q.mk2[63:32], q.w_data, q.w_strb);
          `PCSST_OFS_MK3_LO:  d.mk3[31:0]  = merge(q.mk3[31:0], q.w_data, q.w_strb);
          `PCSST_OFS_MK3_HI:  d.mk3[63:32] = merge(q.mk3[63:32], q.w_data, q.w_strb);
          default: ;
        endcase
      end
    end
    // Read channel.
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_val;
      d.rresp  = rd_resp;
    end

    // Receive status levels, one register stage from the datapath.
    d.lock    = lane_lock_in;
    d.aligned = lanes_deskewed & ~rx_rst;
    d.hi_ber  = ber_over_limit;
    d.lfault  = decoder_in_init;
    d.pfault  = decoder_in_init | ~d.aligned;
    // The FIFO error stays up until the receive port is reset.
    if (rx_rst) begin
      d.fifo_err = 1'b0;
    end else if (cc_fifo_underflow || cc_fifo_overflow) begin
      d.fifo_err = 1'b1;
    end

    // Increments are qualified; a held port reset silences every valid.
    d.sh_vld  = lane_word_strobe & {4{~rx_rst}};
    d.sh_err  = sh_next;
    d.bad     = bad_code_in;
    d.bad_vld = bad_code_strobe & ~rx_rst;
    d.rx_hdr  = rx_tp_header;
    d.tp_vld  = rx_scr.dout_valid & rx_tp_on;
    d.tp_err  = 8'h00;
    if (rx_scr.dout_valid && rx_tp_on) begin
      d.tp_err = popcount({q.rx_hdr ^ `PCSST_HDR_CTRL,
                           rx_scr.dout ^ `PCSST_IDLE_PAYLOAD});
    end

    // Transmit header is registered with its word, in step with the scrambler output.
    if (tx_strobe_in) begin
      d.tx_hdr = tx_tp_on ? `PCSST_HDR_CTRL : tx_header_in;
    end

    // Interrupt events; a new event wins over a clear in the same cycle.
    irq_ev[`PCSST_IRQ_FIFO]   = d.fifo_err & ~q.fifo_err;
    irq_ev[`PCSST_IRQ_HI_BER] = d.hi_ber & ~q.hi_ber;
    irq_ev[`PCSST_IRQ_ALIGN]  = q.aligned & ~d.aligned;
    irq_ev[`PCSST_IRQ_TP_ERR] = d.tp_vld & (d.tp_err != 8'h00);
    if (q.aw_got && q.w_got && !q.bvalid && q.aw_addr == `PCSST_OFS_IRQ_CLR && q.w_strb[0]) begin
      d.irq_st = q.irq_st & ~q.w_data[3:0];
    end
    d.irq_st = d.irq_st | irq_ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane sync-header increments.
  for (genvar l = 0; l < 4; l++) begin : g_lane
    assign sh_next[l*4 +: 4] = lane_word_strobe[l] ? lane_sh_err_in[l*4 +: 4] : 4'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q       <= '0;
      q.ctrl  <= `PCSST_CTRL_RST;
      q.rx_sp <= `PCSST_SPACING_RST;
      q.tx_sp <= `PCSST_SPACING_RST;
      q.mk2   <= `PCSST_MARKER_RST;
      q.mk3   <= `PCSST_MARKER_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign s_axi_awready         = ~q.aw_got & ~q.bvalid;
  assign s_axi_wready          = ~q.w_got & ~q.bvalid;
  assign s_axi_bvalid          = q.bvalid;
  assign s_axi_bresp           = q.bresp;
  assign s_axi_arready         = ~q.rvalid;
  assign s_axi_rvalid          = q.rvalid;
  assign s_axi_rdata           = q.rdata;
  assign s_axi_rresp           = q.rresp;
  assign irq                   = |(q.irq_st & q.irq_en);
  assign rx_block_lock         = q.lock;
  assign rx_aligned            = q.aligned;
  assign rx_excess_error_rate  = q.hi_ber;
  assign rx_local_fault        = q.lfault;
  assign rx_path_fault         = q.pfault;
  assign rx_fifo_error         = q.fifo_err;
  assign rx_sh_err_inc         = q.sh_err;
  assign rx_sh_err_valid       = q.sh_vld;
  assign rx_bad_code_inc       = q.bad;
  assign rx_bad_code_valid     = q.bad_vld;
  assign rx_test_err_inc       = q.tp_err;
  assign rx_test_err_valid     = q.tp_vld;
  assign rx_port_reset         = rx_rst;
  assign tx_port_reset         = tx_rst;
  assign tx_word_out           = tx_scr.dout;
  assign tx_header_out         = q.tx_hdr;
  assign tx_strobe_out         = tx_scr.dout_valid;
  assign rx_marker_spacing     = q.rx_sp;
  assign tx_marker_spacing     = q.tx_sp;
  assign tx_lane2_marker_value = q.mk2;
  assign tx_lane3_marker_value = q.mk3;
endmodule : pcsst_lane_status

// [inc/pcsst_params.svh]
// Register map, field positions, reset values and coding constants of the lane status block.
`ifndef PCSST_PARAMS_SVH
`define PCSST_PARAMS_SVH

`define PCSST_OFS_CTRL      8'h00
`define PCSST_OFS_STATUS    8'h04
`define PCSST_OFS_IRQ_STAT  8'h08
`define PCSST_OFS_IRQ_CLR   8'h0C
`define PCSST_OFS_IRQ_EN    8'h10
`define PCSST_OFS_SPACING   8'h14
`define PCSST_OFS_MK2_LO    8'h18
`define PCSST_OFS_MK2_HI    8'h1C
`define PCSST_OFS_MK3_LO    8'h20
`define PCSST_OFS_MK3_HI    8'h24

`define PCSST_CTRL_RX_TP    0
`define PCSST_CTRL_TX_TP    1
`define PCSST_CTRL_RX_RST   2
`define PCSST_CTRL_TX_RST   3

`define PCSST_ST_LOCK_LSB   0
`define PCSST_ST_ALIGNED    4
`define PCSST_ST_HI_BER     5
`define PCSST_ST_LFAULT     6
`define PCSST_ST_FIFO_ERR   7
`define PCSST_ST_PFAULT     8

`define PCSST_IRQ_FIFO      0
`define PCSST_IRQ_HI_BER    1
`define PCSST_IRQ_ALIGN     2
`define PCSST_IRQ_TP_ERR    3

`define PCSST_CTRL_RST      4'h0
`define PCSST_SPACING_RST   16'h3FFF
`define PCSST_MARKER_RST    64'h0000000000000000

`define PCSST_IDLE_PAYLOAD  64'h000000000000001E
`define PCSST_HDR_CTRL      2'h2
`define PCSST_SCR_TAP_A     38
`define PCSST_SCR_TAP_B     57
`define PCSST_RESP_OKAY     2'h0
`define PCSST_RESP_SLVERR   2'h2

`endif

// [inc/pcsst_pkg.sv]
// Types shared by the lane status block and its scrambler.
package pcsst_pkg;
  typedef logic [3:0]  pcsst_lane_t;
  typedef logic [63:0] pcsst_word_t;
  typedef logic [15:0] pcsst_nibs_t;

  typedef struct packed {
    logic [57:0] lfsr;
    logic [63:0] dout;
    logic        dvalid;
  } pcsst_scr_state_t;

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  ctrl;
    logic [15:0] rx_sp;
    logic [15:0] tx_sp;
    logic [63:0] mk2;
    logic [63:0] mk3;
    logic [3:0]  irq_st;
    logic [3:0]  irq_en;
    logic [3:0]  lock;
    logic        aligned;
    logic        hi_ber;
    logic        lfault;
    logic        pfault;
    logic        fifo_err;
    logic [15:0] sh_err;
    logic [3:0]  sh_vld;
    logic [1:0]  bad;
    logic        bad_vld;
    logic [7:0]  tp_err;
    logic        tp_vld;
    logic [1:0]  tx_hdr;
    logic [1:0]  rx_hdr;
  } pcsst_state_t;
endpackage : pcsst_pkg

// [inc/pcsst_scr_if.sv]
// Word stream between the status block and one self-synchronising scrambler.
`timescale 1ns/1ps
interface pcsst_scr_if;
  logic [63:0] din;
  logic        din_valid;
  logic        clear;
  logic [63:0] dout;
  logic        dout_valid;
  modport host (output din, output din_valid, output clear, input dout, input dout_valid);
  modport core (input din, input din_valid, input clear, output dout, output dout_valid);
endinterface : pcsst_scr_if

// [hw/pcsst_scrambler.sv]
// Self-synchronising x^58 + x^39 + 1 scrambler or descrambler, one 64-bit word per strobe.
`timescale 1ns/1ps
module pcsst_scrambler #(
  parameter bit DESCRAMBLE = 1'b0
) (
  // Clock, reset and enable.
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   ce,
  // Word stream.
  pcsst_scr_if.core   scr
);
  import pcsst_pkg::*;
  `include "pcsst_params.svh"

  pcsst_scr_state_t q;
  pcsst_scr_state_t d;
  logic [57:0]      st;
  logic [63:0]      ob;
  logic             sb;

  ////////////////////////////////////////////////////////////////////////////
  // The first bit on the wire (bit 0) enters the polynomial first.
  always_comb begin
    d = q;
    d.dvalid = 1'b0;
    st = q.lfsr;
    ob = '0;
    sb = 1'b0;
    if (scr.clear) begin
      d.lfsr = '0;
    end else if (scr.din_valid) begin
      for (int i = 0; i < 64; i++) begin
        sb = scr.din[i] ^ st[`PCSST_SCR_TAP_A] ^ st[`PCSST_SCR_TAP_B];
        ob[i] = sb;
        st = {st[56:0], (DESCRAMBLE ? scr.din[i] : sb)};
      end
      d.lfsr = st;
      d.dout = ob;
      d.dvalid = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign scr.dout = q.dout;
  assign scr.dout_valid = q.dvalid;
endmodule : pcsst_scrambler

// [sim/pcsst_lane_status_props.sv]
// Concurrent checks on the ports of the lane status block.
`timescale 1ns/1ps
module pcsst_lane_status_props (
  // Clock and reset.
  input logic        aclk,
  input logic        aresetn,
  // Receive and transmit inputs.
  input logic [3:0]  lane_lock_in,
  input logic [15:0] lane_sh_err_in,
  input logic [3:0]  lane_word_strobe,
  input logic [1:0]  bad_code_in,
  input logic        bad_code_strobe,
  input logic        decoder_in_init,
  input logic        lanes_deskewed,
  input logic        ber_over_limit,
  input logic        cc_fifo_underflow,
  input logic        cc_fifo_overflow,
  input logic        rx_tp_strobe,
  input logic        tx_strobe_in,
  // Outputs under watch.
  input logic [3:0]  rx_block_lock,
  input logic        rx_aligned,
  input logic        rx_excess_error_rate,
  input logic        rx_local_fault,
  input logic        rx_path_fault,
  input logic        rx_fifo_error,
  input logic [15:0] rx_sh_err_inc,
  input logic [3:0]  rx_sh_err_valid,
  input logic [1:0]  rx_bad_code_inc,
  input logic        rx_bad_code_valid,
  input logic [7:0]  rx_test_err_inc,
  input logic        rx_test_err_valid,
  input logic        rx_port_reset,
  input logic        tx_port_reset,
  input logic        tx_strobe_out,
  input logic        irq
);
  import pcsst_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // The port reset forces outputs, so each check needs a full cycle out of it.
  logic live_reg;
  always_ff @(posedge aclk) live_reg <= aresetn & !rx_port_reset;
  wire logic run = live_reg & !rx_port_reset;
  wire pcsst_nibs_t vm = {{4{rx_sh_err_valid[3]}}, {4{rx_sh_err_valid[2]}},
                          {4{rx_sh_err_valid[1]}}, {4{rx_sh_err_valid[0]}}};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_lock_tracks: assert property (run |-> rx_block_lock == $past(lane_lock_in))
    else $error("block lock does not follow lane lock");
  a_level_status: assert property (run |-> rx_aligned == $past(lanes_deskewed)
    && rx_excess_error_rate == $past(ber_over_limit))
    else $error("aligned or error rate level wrong");
  a_fault_split: assert property (run |-> rx_local_fault == $past(decoder_in_init)
    && rx_path_fault == ($past(decoder_in_init) || !rx_aligned))
    else $error("fault levels wrong");
  a_fifo_sets: assert property (run && $past(cc_fifo_underflow || cc_fifo_overflow)
    |-> rx_fifo_error)
    else $error("fifo error not raised");
  a_fifo_sticky: assert property (rx_fifo_error && !rx_port_reset |=>
    rx_fifo_error || rx_port_reset)
    else $error("fifo error dropped without port reset");
  a_lane_incs: assert property (run |-> rx_sh_err_valid == $past(lane_word_strobe)
    && (rx_sh_err_inc & vm) == ($past(lane_sh_err_in) & vm))
    else $error("sync header increment wrong");
  a_bad_code: assert property (run |-> rx_bad_code_valid == $past(bad_code_strobe)
    && (!rx_bad_code_valid || rx_bad_code_inc == $past(bad_code_in)))
    else $error("code violation increment wrong");
  a_test_pulse: assert property (!$past(rx_tp_strobe, 2) |-> !rx_test_err_valid)
    else $error("test error valid without a word");
  a_tx_latency: assert property ($past(aresetn) |->
    tx_strobe_out == $past(tx_strobe_in && !tx_port_reset))
    else $error("transmit strobe latency wrong");
  c_fifo_irq: cover property (rx_fifo_error && irq);
  c_test_clean: cover property (rx_test_err_valid && rx_test_err_inc == 8'h00);
  c_bad_code: cover property (rx_bad_code_valid && rx_bad_code_inc != 2'h0);
endmodule : pcsst_lane_status_props

bind pcsst_lane_status pcsst_lane_status_props u_props (.*);

// [sim/pcsst_mac_model.sv]
// Transmit word source for the MAC side.
`timescale 1ns/1ps
module pcsst_mac_model (
  // Clock and reset.
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // Transmit word stream.
  output logic [63:0] word,
  output logic [1:0]  hdr,
  output logic        stb
);
  logic s;
  // Idle cycles show the inverted word so a stale value is never mistaken for data.
  always @(posedge aclk) begin
    s = ($urandom_range(0, 3) != 0);
    if (!aresetn) begin
      stb <= 1'b0;
      word <= 64'h0;
      hdr <= 2'h1;
    end else begin
      stb <= s;
      word <= s ? {$urandom, $urandom} : ~word;
      hdr <= s ? 2'($urandom_range(1, 2)) : ~hdr;
    end
  end
endmodule : pcsst_mac_model

// [sim/testbench.sv]
// Self-checking bench for the lane status block.
`timescale 1ns/1ps
module testbench;
  import pcsst_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, rnd = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_test_err_inc;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, w;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, rx_higher_mode = 0, tx_higher_mode = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, rx_tp_header, rx_bad_code_inc;
  logic [1:0]  bad_code_in = 2'h0, tx_header_in, tx_header_out;
  pcsst_lane_t lane_lock_in = 4'h0, lane_word_strobe = 4'h0, rx_block_lock, rx_sh_err_valid;
  pcsst_nibs_t lane_sh_err_in = 16'h0, rx_sh_err_inc;
  logic        bad_code_strobe = 0, decoder_in_init = 0, lanes_deskewed = 0, ber_over_limit = 0;
  logic        cc_fifo_underflow = 0, cc_fifo_overflow = 0, rx_tp_strobe, tx_strobe_in;
  logic        tx_strobe_out, rx_aligned, rx_excess_error_rate, rx_local_fault, rx_path_fault;
  logic        rx_fifo_error, rx_bad_code_valid, rx_test_err_valid, rx_port_reset, tx_port_reset;
  logic [15:0] rx_marker_spacing, tx_marker_spacing;
  pcsst_word_t rx_tp_word, tx_word_in, tx_word_out, tx_lane2_marker_value, tx_lane3_marker_value;
  logic [31:0] m [4];
  int          n_errors = 0, cmp_count = 0, tv = 0, tnz = 0, i;
  ////////////////////////////////////////////////////////////////////////////////
  // The transmit output loops back into the test-pattern checker.
  assign rx_tp_word = tx_word_out;
  assign rx_tp_header = tx_header_out;
  assign rx_tp_strobe = tx_strobe_out;
  pcsst_lane_status dut (.*);
  pcsst_mac_model u_mac (.aclk(aclk), .aresetn(aresetn), .word(tx_word_in),
                         .hdr(tx_header_in), .stb(tx_strobe_in));
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    if (rnd) begin
      {lane_lock_in, lane_sh_err_in, lane_word_strobe, bad_code_in, bad_code_strobe,
       decoder_in_init, lanes_deskewed, ber_over_limit} <= 30'($urandom);
    end
    if (rx_test_err_valid === 1'b1) begin
      tv++;
      if (rx_test_err_inc !== 8'h00) tnz++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  task automatic tally(input int k);
    @(negedge aclk);
    tv = 0;
    tnz = 0;
    cyc(k);
  endtask : tally
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    tb = 1'b0;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!tb) chk(64'h0, 64'h1);
    if (!tb) final_report();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    tr = 1'b0;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!tr) chk(64'h0, 64'h1);
    if (!tr) final_report();
  endtask : rd
  function automatic logic [31:0] st_exp(logic [3:0] lk, logic al, logic ber, logic lf);
    return {23'h0, lf | !al, 1'b0, lf, ber, al, lk};
  endfunction : st_exp
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h75A7));
    cyc(6);
    aresetn <= 1'b1;
    rd(8'h00, v, rsp); chk(v, 32'h0);
    rd(8'h14, v, rsp); chk(v, 32'h3FFF3FFF);
    wr(8'h18, 32'h1234, rsp); chk(rsp, 2'h2);
    wr(8'h04, 32'h1, rsp); chk(rsp, 2'h2);
    rd(8'h30, v, rsp); chk(rsp, 2'h2);
    chk(tx_lane2_marker_value, 64'h0);
    wr(8'h00, 32'hC, rsp);
    w = $urandom;
    wr(8'h14, w, rsp); chk({rx_marker_spacing, tx_marker_spacing}, {w[15:0], w[31:16]});
    for (i = 0; i < 4; i++) begin
      m[i] = $urandom;
      wr(8'(8'h18 + 4 * i), m[i], rsp);
    end
    chk(tx_lane2_marker_value, {m[1], m[0]});
    chk(tx_lane3_marker_value, {m[3], m[2]});
    wr(8'h00, 32'h0, rsp);
    // Random traffic around a receive port reset.
    rnd <= 1'b1;
    cyc(100);
    wr(8'h00, 32'h4, rsp);
    cyc(3);
    chk({rx_sh_err_valid, rx_bad_code_valid, rx_aligned}, 6'h0);
    wr(8'h00, 32'h0, rsp);
    cyc(100);
    rnd <= 1'b0;
    cyc(1);
    w = $urandom;
    {lane_lock_in, lanes_deskewed, ber_over_limit, decoder_in_init} <= w[6:0];
    cyc(2);
    rd(8'h04, v, rsp); chk(v, st_exp(w[6:3], w[2], w[1], w[0]));
    // Looped-back scrambled idle must check clean.
    wr(8'h00, 32'h3, rsp);
    cyc(20);
    tally(40); chk(tnz, 0);
    chk(tv != 0, 1'b1);
    tx_higher_mode <= 1'b1;
    cyc(5);
    tally(40); chk(tnz != 0, 1'b1);
    tx_higher_mode <= 1'b0;
    rx_higher_mode <= 1'b1;
    cyc(5);
    tally(20); chk(tv, 0);
    rx_higher_mode <= 1'b0;
    wr(8'h00, 32'h2, rsp);
    tally(20); chk(tv, 0);
    // Underflow, then overflow, each cleared by a port reset.
    wr(8'h10, 32'h1, rsp);
    for (i = 0; i < 2; i++) begin
      {cc_fifo_underflow, cc_fifo_overflow} <= (i == 0) ? 2'h2 : 2'h1;
      cyc(1);
      {cc_fifo_underflow, cc_fifo_overflow} <= 2'h0;
      cyc(3);
      chk({rx_fifo_error, irq}, 2'h3);
      rd(8'h08, v, rsp); chk(v[0], 1'b1);
      wr(8'h10, 32'h0, rsp); chk(irq, 1'b0);
      wr(8'h10, 32'h1, rsp); chk(irq, 1'b1);
      wr(8'h0C, 32'h1, rsp); chk(irq, 1'b0);
      wr(8'h00, 32'h4, rsp);
      wr(8'h00, 32'h0, rsp); chk(rx_fifo_error, 1'b0);
    end
    cyc(5);
    final_report();
  end
  initial begin
    cyc(30000);
    chk(64'h0, 64'h1);
    final_report();
  end
endmodule : testbench
